// [hdl/amps_seq.sv]
// amplifier mode and protection sequencer with apb registers
// assumes analog sensors give synchronous flags; carrier ticks arrive as pulses
`timescale 1ns/10ps
`include "amps_cfg.svh"
module amps_seq #(
  parameter int TW = 20,
  parameter logic [TW-1:0] MUTE_TICKS = TW'(`AMPS_MUTE_TICKS),
  parameter logic [TW-1:0] RETRY_TICKS = TW'(`AMPS_RETRY_TICKS),
  parameter logic [TW-1:0] UV_TICKS = TW'(`AMPS_UV_TICKS)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [1:0] mode_sel,
  input wire logic osc_dc_high,
  input wire logic int_osc_tick,
  input wire logic ext_osc_tick,
  input wire logic temp_over_150,
  input wire logic temp_below_130,
  input wire logic over_current,
  input wire logic out_short,
  input wire logic supply_under,
  input wire logic supply_over,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic int_osc_en,
  output logic power_stage_en,
  output logic mute_en,
  output logic amp_bias_en,
  output logic irq
);
  amps_pkg::amps_state_e st_ff, nxt_st;
  logic ot_ff, nxt_ot;
  logic oc_ff, nxt_oc;
  logic uv_ff, nxt_uv;
  logic [`AMPS_EV_W-1:0] stat_ff, nxt_stat;
  logic [`AMPS_EV_W-1:0] mask_ff, nxt_mask;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rd_ff, nxt_rd;
  logic [`AMPS_EV_W-1:0] ev;
  logic tick, tstart, tbusy, tdone, prot, wr, rd;
  logic [TW-1:0] tload;
  amps_pkg::amps_req_e req;

  // decode mode request, software can force standby or mute
  always_comb begin
    req = amps_pkg::amps_req_e'(mode_sel); // [R1] [R13]
    if (mode_sel == 2'b11) req = amps_pkg::AMPS_REQ_MUTE;
    if (ctrl_ff[0]) req = amps_pkg::AMPS_REQ_STBY;
    else if (ctrl_ff[1] && req == amps_pkg::AMPS_REQ_OPER) req = amps_pkg::AMPS_REQ_MUTE;
  end

  // carrier source select: dc level on osc pin turns internal off
  assign int_osc_en = ~osc_dc_high; // [R3] [R4]
  assign tick = osc_dc_high ? ext_osc_tick : int_osc_tick; // [R14]

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign prot = ot_ff | oc_ff | uv_ff | supply_over | over_current | temp_over_150; // [R15]

  amps_tick_timer #(.W(TW)) u_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(tstart),
    .load(tload),
    .tick(tick),
    .busy(tbusy),
    .done(tdone)
  );

  // protection latches and sequencing state
  always_comb begin
    nxt_ot = ot_ff;
    nxt_oc = oc_ff;
    nxt_uv = uv_ff;
    nxt_st = st_ff;
    tstart = 1'b0;
    tload = MUTE_TICKS;
    if (temp_over_150) nxt_ot = 1'b1; // [R5]
    else if (temp_below_130) nxt_ot = 1'b0; // [R5]
    if (supply_under) nxt_uv = 1'b1; // [R11]
    if (over_current) begin
      nxt_oc = 1'b1; // [R6]
      tstart = 1'b1;
      tload = RETRY_TICKS; // [R7]
    end else if (uv_ff && !supply_under && !tbusy && !oc_ff) begin
      tstart = 1'b1;
      tload = UV_TICKS; // [R11]
    end
    // a fresh fault in the same cycle as the timer end keeps the latch set
    if (oc_ff && tdone && !over_current) nxt_oc = 1'b0; // [R7]
    if (uv_ff && tdone && !oc_ff && !supply_under) nxt_uv = 1'b0; // [R11]
    case (st_ff)
      amps_pkg::AMPS_ST_STBY: begin
        if (req != amps_pkg::AMPS_REQ_STBY) nxt_st = amps_pkg::AMPS_ST_CHECK; // [R8]
      end
      amps_pkg::AMPS_ST_CHECK: begin
        if (req == amps_pkg::AMPS_REQ_STBY) nxt_st = amps_pkg::AMPS_ST_STBY;
        else if (!out_short) nxt_st = amps_pkg::AMPS_ST_MUTE; // [R8] [R9]
      end
      amps_pkg::AMPS_ST_MUTE: begin
        if (req == amps_pkg::AMPS_REQ_STBY) nxt_st = amps_pkg::AMPS_ST_STBY;
        else if (req == amps_pkg::AMPS_REQ_OPER && !prot) begin
          nxt_st = amps_pkg::AMPS_ST_HOLD;
          if (!over_current && !(uv_ff && !tbusy)) begin
            tstart = 1'b1;
            tload = MUTE_TICKS; // [R2]
          end
        end
      end
      amps_pkg::AMPS_ST_HOLD: begin
        if (req != amps_pkg::AMPS_REQ_OPER || prot) nxt_st = amps_pkg::AMPS_ST_MUTE;
        else if (tdone) nxt_st = amps_pkg::AMPS_ST_OPER; // [R2]
      end
      amps_pkg::AMPS_ST_OPER: begin
        if (req == amps_pkg::AMPS_REQ_STBY) nxt_st = amps_pkg::AMPS_ST_STBY;
        else if (req == amps_pkg::AMPS_REQ_MUTE) nxt_st = amps_pkg::AMPS_ST_MUTE;
        else if (prot) nxt_st = amps_pkg::AMPS_ST_FAULT; // [R10] [R15]
      end
      amps_pkg::AMPS_ST_FAULT: begin
        if (req == amps_pkg::AMPS_REQ_STBY) nxt_st = amps_pkg::AMPS_ST_STBY;
        else if (!prot) nxt_st = amps_pkg::AMPS_ST_MUTE;
      end
      default: nxt_st = amps_pkg::AMPS_ST_STBY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= amps_pkg::AMPS_ST_STBY;
      ot_ff <= 1'b0;
      oc_ff <= 1'b0;
      uv_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      ot_ff <= nxt_ot;
      oc_ff <= nxt_oc;
      uv_ff <= nxt_uv;
    end
  end

  // power stage off combinationally on live over-current, overvoltage or over-temperature, one clock later on undervoltage, well under 1 us
  assign power_stage_en = ~sys_rst & ~prot & ~out_short_block() &
                          (st_ff == amps_pkg::AMPS_ST_MUTE || st_ff == amps_pkg::AMPS_ST_HOLD ||
                           st_ff == amps_pkg::AMPS_ST_OPER); // [R6] [R12] [R9]
  assign mute_en = (st_ff != amps_pkg::AMPS_ST_OPER); // [R1]
  assign amp_bias_en = (st_ff != amps_pkg::AMPS_ST_STBY); // [R1]

  function automatic logic out_short_block();
    out_short_block = (st_ff == amps_pkg::AMPS_ST_CHECK) & out_short;
  endfunction

  // events and register file
  assign ev = {st_ff == amps_pkg::AMPS_ST_OPER, st_ff == amps_pkg::AMPS_ST_CHECK && out_short,
               supply_over, supply_under, over_current, temp_over_150};

  always_comb begin
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    nxt_ctrl = ctrl_ff;
    nxt_rd = rd_ff;
    if (wr && paddr == `AMPS_REG_CTRL) nxt_ctrl = pwdata[1:0];
    if (wr && paddr == `AMPS_REG_MASK) nxt_mask = pwdata[`AMPS_EV_W-1:0];
    if (wr && paddr == `AMPS_REG_IRQ) nxt_stat = stat_ff & ~pwdata[`AMPS_EV_W-1:0];
    nxt_stat = nxt_stat | ev; // set wins over clear
    if (rd) begin
      case (paddr)
        `AMPS_REG_CTRL: nxt_rd = {30'h0, ctrl_ff};
        `AMPS_REG_STAT: nxt_rd = {23'h0, st_ff, ot_ff, oc_ff, uv_ff, supply_over, out_short,
                                  tbusy};
        `AMPS_REG_IRQ: nxt_rd = {26'h0, stat_ff};
        `AMPS_REG_MASK: nxt_rd = {26'h0, mask_ff};
        default: nxt_rd = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_ff <= '0;
      mask_ff <= `AMPS_EV_W'(`AMPS_MASK_RST);
      ctrl_ff <= 2'(`AMPS_CTRL_RST);
      rd_ff <= 32'h0;
    end else if (ce) begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      ctrl_ff <= nxt_ctrl;
      rd_ff <= nxt_rd;
    end
  end

  assign prdata = rd_ff;
  assign pready = ce;
  assign pslverr = 1'b0;
  assign irq = |(stat_ff & mask_ff);

  // checks
  property p_ocoff;
    @(posedge clk) disable iff (sys_rst) over_current |-> !power_stage_en;
  endproperty
  a_ocoff: assert property (p_ocoff) else $error("stage on during over-current"); // [R6]
  property p_otoff;
    @(posedge clk) disable iff (sys_rst) ot_ff |-> !power_stage_en;
  endproperty
  a_otoff: assert property (p_otoff) else $error("stage on while hot"); // [R5]
  property p_ovoff;
    @(posedge clk) disable iff (sys_rst) supply_over |-> !power_stage_en;
  endproperty
  a_ovoff: assert property (p_ovoff) else $error("stage on over voltage"); // [R12]
  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      (st_ff == amps_pkg::AMPS_ST_MUTE && nxt_st == amps_pkg::AMPS_ST_HOLD && ce) |=>
      st_ff != amps_pkg::AMPS_ST_OPER;
  endproperty
  a_hold: assert property (p_hold) else $error("mute hold skipped"); // [R2]
  property p_chk;
    @(posedge clk) disable iff (sys_rst)
      (st_ff == amps_pkg::AMPS_ST_CHECK && out_short) |-> !power_stage_en;
  endproperty
  a_chk: assert property (p_chk) else $error("stage on during short"); // [R8]
  property p_stb;
    @(posedge clk) disable iff (sys_rst) st_ff == amps_pkg::AMPS_ST_STBY |-> !amp_bias_en;
  endproperty
  a_stb: assert property (p_stb) else $error("bias on in standby"); // [R1]
  property p_osc;
    @(posedge clk) osc_dc_high |-> !int_osc_en;
  endproperty
  a_osc: assert property (p_osc) else $error("internal osc left on"); // [R4]
  property p_uv;
    @(posedge clk) disable iff (sys_rst) uv_ff |-> !power_stage_en;
  endproperty
  a_uv: assert property (p_uv) else $error("stage on in undervoltage"); // [R11]
  c_oper: cover property (@(posedge clk) st_ff == amps_pkg::AMPS_ST_OPER);
  c_fault: cover property (@(posedge clk) st_ff == amps_pkg::AMPS_ST_FAULT);
  c_irq: cover property (@(posedge clk) irq);
endmodule // amps_seq

// [shared/amps_cfg.svh]
// constants for the amplifier mode and protection sequencer
// assumes a 20 mhz system clock and a carrier-tick input from the oscillator select
// Functional notes
// R1: standby, mute and operating modes from mode input
// R2: hold mute about 150 ms before operating
// R3: internal carrier about 350 kHz, resistor set
// R4: dc level on osc pin selects external clock
// R5: stop above 150 C, resume near 130 C
// R6: over-current shuts power stage within 1 us
// R7: retry every 100 ms after over-current
// R8: short check at standby to mute, wait open
// R9: short check before power stage enable
// R10: short check only at start-up, then current limit
// R11: undervoltage stops; restart 100 ms after recovery; if the timer is busy (mute hold) code restarts when that count ends
// R12: overvoltage disables stage until supply drops
// R13: external party drives legal mode levels
// R14: timers count active carrier oscillator cycles
// R15: any protection overrides requested mode
`ifndef AMPS_CFG_SVH
`define AMPS_CFG_SVH
`define AMPS_INT_OSC_HZ 350000
`define AMPS_MUTE_HOLD_MS 150
`define AMPS_RETRY_MS 100
`define AMPS_UV_RESTART_MS 100
`define AMPS_OC_LIMIT_NS 1000
`define AMPS_CLK_NS 50
`define AMPS_MUTE_TICKS ((`AMPS_INT_OSC_HZ / 1000) * `AMPS_MUTE_HOLD_MS)
`define AMPS_RETRY_TICKS ((`AMPS_INT_OSC_HZ / 1000) * `AMPS_RETRY_MS)
`define AMPS_UV_TICKS ((`AMPS_INT_OSC_HZ / 1000) * `AMPS_UV_RESTART_MS)
`define AMPS_OC_MAX_CYC (`AMPS_OC_LIMIT_NS / `AMPS_CLK_NS)
`define AMPS_REG_CTRL 32'h00000000
`define AMPS_REG_STAT 32'h00000004
`define AMPS_REG_IRQ 32'h00000008
`define AMPS_REG_MASK 32'h0000000c
`define AMPS_CTRL_RST 32'h00000000
`define AMPS_MASK_RST 32'h00000000
`define AMPS_EV_OT 0
`define AMPS_EV_OC 1
`define AMPS_EV_UV 2
`define AMPS_EV_OV 3
`define AMPS_EV_SC 4
`define AMPS_EV_RUN 5
`define AMPS_EV_W 6
`endif

// [shared/amps_pkg.sv]
// types for the amplifier mode and protection sequencer
// assumes nothing beyond the cfg header
package amps_pkg;
  typedef enum logic [1:0] {
    AMPS_REQ_STBY = 2'b00,
    AMPS_REQ_MUTE = 2'b01,
    AMPS_REQ_OPER = 2'b10
  } amps_req_e;
  typedef enum logic [2:0] {
    AMPS_ST_STBY = 3'b000,
    AMPS_ST_CHECK = 3'b001,
    AMPS_ST_MUTE = 3'b010,
    AMPS_ST_HOLD = 3'b011,
    AMPS_ST_OPER = 3'b100,
    AMPS_ST_FAULT = 3'b101
  } amps_state_e;
endpackage

// [hdl/amps_tick_timer.sv]
// down counter of carrier ticks, raises done at terminal count
// assumes tick is one-cycle pulses from the active oscillator
`timescale 1ns/10ps
module amps_tick_timer #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [W-1:0] load,
  input wire logic tick,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;
  logic done_ff;
  logic nxt_done;

  // counts ticks of the selected carrier
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = load;
      nxt_busy = 1'b1;
    end else if (busy_ff && tick) begin // [R14]
      if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_cnt = '0;
      end else begin
        nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff & ce;
endmodule // amps_tick_timer

// [tb/amps_far_model.sv]
// far side: carrier oscillators and die temperature sensor
// assumes the bench sets the temperature and the carrier choice
`timescale 1ns/10ps
module amps_far_model #(
  parameter int DIV = 7
) (
  input wire logic clk,
  input wire logic ext_sel,
  input wire logic [7:0] temp_c,
  output logic int_osc_tick,
  output logic ext_osc_tick,
  output logic temp_over_150,
  output logic temp_below_130
);
  int cnt = 0;
  // one pulse every DIV cycles from the chosen carrier only
  always @(posedge clk) begin
    cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
    int_osc_tick <= !ext_sel && cnt == 0;
    ext_osc_tick <= ext_sel && cnt == 0;
  end
  // sensor flags with the two trip points
  assign temp_over_150 = temp_c > 8'd150;
  assign temp_below_130 = temp_c <= 8'd130;
endmodule // amps_far_model

// [tb/amps_seq_tb.sv]
// testbench of the amplifier mode and protection sequencer
// assumes short timer counts and the far side model
`timescale 1ns/10ps
`include "amps_cfg.svh"
module amps_seq_tb;
  localparam int DIV = 7;
  localparam int HOLD = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] mode_sel = 2'b00;
  logic osc_dc_high = 1'b0;
  logic over_current = 1'b0;
  logic out_short = 1'b0;
  logic supply_under = 1'b0;
  logic supply_over = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] temp_c = 8'h19;
  logic [7:0] t;
  logic [7:0] corner [3] = '{8'd151, 8'd140, 8'd130};
  logic hot = 1'b0;
  logic [31:0] prdata, rd, seed;
  logic pready, pslverr, int_osc_en, power_stage_en, mute_en, amp_bias_en, irq;
  logic int_osc_tick, ext_osc_tick, temp_over_150, temp_below_130;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int waited;
  amps_seq #(.MUTE_TICKS(20'(HOLD)), .RETRY_TICKS(20'(HOLD)), .UV_TICKS(20'(HOLD))) DUT (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .mode_sel(mode_sel), .osc_dc_high(osc_dc_high),
    .int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick), .temp_over_150(temp_over_150),
    .temp_below_130(temp_below_130), .over_current(over_current), .out_short(out_short),
    .supply_under(supply_under), .supply_over(supply_over), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_osc_en(int_osc_en), .power_stage_en(power_stage_en),
    .mute_en(mute_en), .amp_bias_en(amp_bias_en), .irq(irq));
  amps_far_model #(.DIV(DIV)) FAR (.clk(clk), .ext_sel(osc_dc_high), .temp_c(temp_c),
    .int_osc_tick(int_osc_tick), .ext_osc_tick(ext_osc_tick),
    .temp_over_150(temp_over_150), .temp_below_130(temp_below_130));
  // clock source
  initial begin
    forever #25 clk = ~clk;
  end
  // xorshift source of stimulus
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // expected over-temperature latch with hysteresis
  function automatic logic hot_after(input logic h, input logic [7:0] v);
    return (v > 8'd150) || (h && v > 8'd130);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for the power stage level, sampled at falling edges
  task automatic wait_stage(input logic v, input int n);
    waited = 0;
    while (waited < n) begin
      @(negedge clk);
      if (power_stage_en === v) break;
      waited++;
    end
  endtask
  // bounded wait for the end of the mute hold, sampled at falling edges
  task automatic wait_mute(input int n);
    waited = 0;
    while (waited < n) begin
      @(negedge clk);
      if (mute_en === 1'b0) break;
      waited++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    seed = 32'h95a1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("stage", 0, power_stage_en);
    chk("mute", 1, mute_en);
    chk("bias", 0, amp_bias_en);
    chk("int_osc", 1, int_osc_en);
    apb(1'b0, `AMPS_REG_MASK, 32'h0);
    chk("mask_rst", `AMPS_MASK_RST, rd);
    apb(1'b0, 32'h40, 32'h0);
    chk("unmapped", 0, rd);
    seed = xs(seed);
    apb(1'b1, `AMPS_REG_MASK, seed & 32'h3f);
    apb(1'b0, `AMPS_REG_MASK, 32'h0);
    chk("mask_rw", seed & 32'h3f, rd & 32'h3f);
    apb(1'b1, `AMPS_REG_MASK, 32'h0);
    // start-up with a shorted output
    @(posedge clk);
    out_short <= 1'b1;
    mode_sel <= 2'b01;
    repeat (40) @(posedge clk);
    apb(1'b0, `AMPS_REG_STAT, 32'h0);
    chk("state", 32'(amps_pkg::AMPS_ST_CHECK), 32'(rd[8:6]));
    @(negedge clk);
    chk("stage_sc", 0, power_stage_en);
    @(posedge clk);
    out_short <= 1'b0;
    mode_sel <= 2'b10;
    wait_mute(400);
    chk("stage_on", 1, power_stage_en);
    chk("hold", 1, 32'(waited >= (HOLD - 1) * DIV));
    chk("mute_op", 0, mute_en);
    // short in normal operation is left to the current limit
    @(posedge clk);
    out_short <= 1'b1;
    osc_dc_high <= 1'b1;
    repeat (20) @(negedge clk);
    chk("stage_run", 1, power_stage_en);
    chk("int_osc_off", 0, int_osc_en);
    @(posedge clk);
    out_short <= 1'b0;
    apb(1'b1, `AMPS_REG_IRQ, 32'h3f);
    // over-current and timed retry, on the external carrier
    @(posedge clk);
    over_current <= 1'b1;
    wait_stage(1'b0, `AMPS_OC_MAX_CYC);
    chk("oc_off", 0, power_stage_en);
    apb(1'b0, `AMPS_REG_IRQ, 32'h0);
    chk("irq_oc", 32'h22, rd & 32'h3f);
    chk("irq_masked", 0, irq);
    apb(1'b1, `AMPS_REG_MASK, 32'h3f);
    @(negedge clk);
    chk("irq_on", 1, irq);
    @(posedge clk);
    over_current <= 1'b0;
    wait_stage(1'b1, 400);
    chk("retry", 1, power_stage_en);
    chk("retry_gap", 1, 32'(waited >= (HOLD - 1) * DIV));
    // undervoltage then overvoltage
    @(posedge clk);
    supply_under <= 1'b1;
    wait_stage(1'b0, 20);
    chk("uv_off", 0, power_stage_en);
    @(posedge clk);
    supply_under <= 1'b0;
    wait_stage(1'b1, 400);
    chk("uv_on", 1, power_stage_en);
    chk("uv_gap", 1, 32'(waited >= (HOLD - 1) * DIV));
    @(posedge clk);
    supply_over <= 1'b1;
    wait_stage(1'b0, 20);
    chk("ov_off", 0, power_stage_en);
    @(posedge clk);
    supply_over <= 1'b0;
    wait_stage(1'b1, 400);
    chk("ov_on", 1, power_stage_en);
    // corner and random temperatures
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      t = (i < 3) ? corner[i] : seed[7:0];
      hot = hot_after(hot, t);
      @(posedge clk);
      temp_c <= t;
      wait_stage(!hot, 400);
      repeat (40) @(negedge clk);
      chk("temp_stage", 32'(!hot), power_stage_en);
    end
    // back to standby, then clear the sticky flags
    @(posedge clk);
    temp_c <= 8'h19;
    mode_sel <= 2'b00;
    repeat (3) @(negedge clk);
    chk("stby_stage", 0, power_stage_en);
    chk("stby_mute", 1, mute_en);
    apb(1'b1, `AMPS_REG_IRQ, 32'h3f);
    @(negedge clk);
    chk("irq_clr", 0, irq);
    chk("slverr", 0, pslverr);
    // clock enable low: bus stalls
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    chk("ce_stall", 0, pready);
    @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk("ce_run", 1, pready);
    wrap_up;
  end
endmodule // amps_seq_tb
